// file: sufr_defs.svh
// Constants, field positions and timing figures of the upstream framer.
//
// Function
// - Upstream output non-inverted, single-ended.
// - Bit rate divided from link clock.
// - Drive type selects open-drain or push-pull.
// - Every divider setting works in push-pull.
// - Frame length 12 or 16 by format.
// - 12-bit: start, data, parity, two stops.
// - Parity makes data ones count even.
// - 16-bit: start, four address, eight data.
// - Address bits three, four pick slot.
// - Fixed address captured at select rise.
// - Multi-read cycles slots, multiples of four.
// - First address bit flags dropped read.
// - Second address bit high until last frame.
// - Start sending within response time.
// - Response measured select rise to start.
// - Drop reads while upstream busy.
// - Downstream frames decoded regardless of upstream.
// - Writes ignored during preparation, not executed later.
// - Send register value held before write.
// - Stop command aborts and clears requests.
// - Command valid only with 17 pulses.
`ifndef SUFR_DEFS_SVH
`define SUFR_DEFS_SVH

// Core clock period in picoseconds (250 MHz).
`define SUFR_CLK_PS        4000
// Preparation and response times in nanoseconds.
`define SUFR_PREP_SR_NS    1000
`define SUFR_PREP_MR_NS    2000
`define SUFR_RSP_NS        5000
// Downstream frame length in falling link clock edges.
`define SUFR_DS_PULSES     5'h11
// Command code that requests an upstream read.
`define SUFR_CMD_READ      8'h01
// Divider field width and number of four-frame groups.
`define SUFR_DIV_W         4
`define SUFR_MULTI_GROUPS  1
// Frame lengths in bits.
`define SUFR_LEN_SHORT     5'h0c
`define SUFR_LEN_LONG      5'h10
// Fixed upper bits of a frame word.
`define SUFR_STOP_BITS     2'h3
`define SUFR_PAD_SHORT     4'hf

`endif

// file: sufr_pkg.sv
// Types shared by the upstream framer.
package sufr_pkg;

	// Controller states.
	typedef enum logic [1:0] {
		SUFR_IDLE = 2'b00,
		SUFR_PREP = 2'b01,
		SUFR_RUN  = 2'b10
	} sufr_state_t;

	// One upstream frame, first bit in bit 0.
	typedef struct packed {
		logic        long_fmt;
		logic [15:0] bits;
	} sufr_frame_t;

	// A downstream command that is not a read.
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] data;
	} sufr_cmd_t;

endpackage : sufr_pkg

// file: sufr_framer.sv
// Upstream framer of the serial control link, with its command receiver.
`timescale 1ns/1ps
`include "sufr_defs.svh"

module sufr_framer #(
	parameter int DIV_W        = `SUFR_DIV_W,
	parameter int MULTI_GROUPS = `SUFR_MULTI_GROUPS,
	parameter int PREP_SR_NS   = `SUFR_PREP_SR_NS,
	parameter int PREP_MR_NS   = `SUFR_PREP_MR_NS,
	parameter int RSP_NS       = `SUFR_RSP_NS
) (
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Link pins from the host.
	input  wire logic               link_clk_pin,
	input  wire logic               select_n_pin,
	input  wire logic               serial_in_pin,
	// Upstream pin, two-signal form.
	output logic                    upstream_out_o,
	output logic                    upstream_out_oe,
	// Configuration.
	input  wire logic               upstream_drive_type_bit,
	input  wire logic [DIV_W-1:0]   upstream_divider_field,
	input  wire logic               upstream_format_bit,
	input  wire logic               multi_read_mode,
	input  wire logic [3:0]         fixed_address_field,
	input  wire logic               upstream_stop_bit,
	// Register read port.
	output logic [7:0]              read_addr,
	input  wire logic [7:0]         read_data,
	// Write commands towards the register file.
	output logic                    wr_cmd_valid,
	output sufr_pkg::sufr_cmd_t     wr_cmd,
	// Status.
	output logic                    upstream_busy,
	output logic                    read_overflow_flag
);

	localparam int CLK_PS = `SUFR_CLK_PS;
	localparam logic [23:0] PREP_SR_CYC =
		24'((PREP_SR_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [23:0] PREP_MR_CYC =
		24'((PREP_MR_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam int RSP_CYC = (RSP_NS * 1000) / CLK_PS;
	localparam logic [5:0] MULTI_FRAMES = 6'(4 * MULTI_GROUPS);

	// Refuse settings the counters cannot hold, and preparation times not below the response time.
	if (MULTI_GROUPS < 1 || MULTI_GROUPS > 15) begin : g_chk_groups
		$error("MULTI_GROUPS out of range");
	end
	if (DIV_W < 1 || DIV_W > 16) begin : g_chk_div
		$error("DIV_W out of range");
	end
	if (int'(PREP_MR_CYC) >= RSP_CYC ||
		int'(PREP_SR_CYC) >= RSP_CYC) begin : g_chk_rsp
		$error("preparation time must be below response time");
	end

	// Pins pass two flip-flops before any logic reads them.
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       lclk_prev_reg;
	logic       csn_prev_reg;
	logic       lclk_s;
	logic       csn_s;
	logic       si_s;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg     <= 3'h7;
			sync2_reg     <= 3'h7;
			lclk_prev_reg <= 1'b1;
			csn_prev_reg  <= 1'b1;
		end else begin
			sync1_reg     <= {link_clk_pin, select_n_pin, serial_in_pin};
			sync2_reg     <= sync1_reg;
			lclk_prev_reg <= lclk_s;
			csn_prev_reg  <= csn_s;
		end
	end

	assign lclk_s = sync2_reg[2];
	assign csn_s  = sync2_reg[1];
	assign si_s   = sync2_reg[0];

	logic clk_fall;
	logic clk_rise;
	logic csn_rise;

	assign clk_fall = lclk_prev_reg & ~lclk_s;
	assign clk_rise = ~lclk_prev_reg & lclk_s;
	assign csn_rise = ~csn_prev_reg & csn_s;

	// Downstream receiver; it never looks at upstream state.
	logic [16:0] rx_sr_reg;
	logic [16:0] rx_sr_next;
	logic [4:0]  rx_cnt_reg;
	logic [4:0]  rx_cnt_next;
	logic        frame_ok;
	logic        rd_req;
	logic        wr_req;

	always_comb begin
		rx_sr_next  = rx_sr_reg;
		rx_cnt_next = rx_cnt_reg;
		if (csn_s) begin
			rx_cnt_next = 5'h00;
		end else if (clk_fall) begin
			rx_sr_next = {si_s, rx_sr_reg[16:1]};
			if (rx_cnt_reg != 5'h1f) begin
				rx_cnt_next = rx_cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_sr_reg  <= 17'h00000;
			rx_cnt_reg <= 5'h00;
		end else begin
			rx_sr_reg  <= rx_sr_next;
			rx_cnt_reg <= rx_cnt_next;
		end
	end

	// Only a frame of exact length opening with a one is a command.
	assign frame_ok = csn_rise && rx_cnt_reg == `SUFR_DS_PULSES
		&& rx_sr_reg[0];
	assign rd_req = frame_ok && rx_sr_reg[8:1] == `SUFR_CMD_READ;
	assign wr_req = frame_ok && rx_sr_reg[8:1] != `SUFR_CMD_READ;

	// Two-entry frame buffer between builder and serializer.
	sufr_pkg::sufr_frame_t fifo_mem_reg [2];
	sufr_pkg::sufr_frame_t fifo_mem_next [2];
	logic                  fifo_wp_reg;
	logic                  fifo_wp_next;
	logic                  fifo_rp_reg;
	logic                  fifo_rp_next;
	logic [1:0]            fifo_cnt_reg;
	logic [1:0]            fifo_cnt_next;
	logic                  push_valid;
	logic                  push_ready;
	logic                  pop_valid;
	logic                  pop_ready;
	sufr_pkg::sufr_frame_t push_frame;
	logic                  push;
	logic                  pop;

	assign push_ready = fifo_cnt_reg != 2'h2;
	assign pop_valid  = fifo_cnt_reg != 2'h0;
	assign push       = push_valid & push_ready;
	assign pop        = pop_valid & pop_ready;

	always_comb begin
		fifo_mem_next = fifo_mem_reg;
		fifo_wp_next  = fifo_wp_reg;
		fifo_rp_next  = fifo_rp_reg;
		fifo_cnt_next = fifo_cnt_reg;
		if (upstream_stop_bit) begin
			fifo_cnt_next = 2'h0;
			fifo_wp_next  = 1'b0;
			fifo_rp_next  = 1'b0;
		end else begin
			if (push) begin
				fifo_mem_next[fifo_wp_reg] = push_frame;
				fifo_wp_next = ~fifo_wp_reg;
			end
			if (pop) begin
				fifo_rp_next = ~fifo_rp_reg;
			end
			if (push && !pop) begin
				fifo_cnt_next = fifo_cnt_reg + 2'h1;
			end else if (pop && !push) begin
				fifo_cnt_next = fifo_cnt_reg - 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fifo_mem_reg[0] <= '0;
			fifo_mem_reg[1] <= '0;
			fifo_wp_reg     <= 1'b0;
			fifo_rp_reg     <= 1'b0;
			fifo_cnt_reg    <= 2'h0;
		end else begin
			fifo_mem_reg <= fifo_mem_next;
			fifo_wp_reg  <= fifo_wp_next;
			fifo_rp_reg  <= fifo_rp_next;
			fifo_cnt_reg <= fifo_cnt_next;
		end
	end

	// Read controller and frame builder.
	sufr_pkg::sufr_state_t state_reg;
	sufr_pkg::sufr_state_t state_next;
	logic [23:0]           prep_reg;
	logic [23:0]           prep_next;
	logic [5:0]            left_reg;
	logic [5:0]            left_next;
	logic [1:0]            slot_reg;
	logic [1:0]            slot_next;
	logic [7:0]            addr_reg;
	logic [7:0]            addr_next;
	logic [3:0]            fixa_reg;
	logic [3:0]            fixa_next;
	logic                  multi_reg;
	logic                  multi_next;
	logic                  long_reg;
	logic                  long_next;
	logic                  ovf_reg;
	logic                  ovf_next;
	logic                  wr_v_next;
	sufr_pkg::sufr_cmd_t   wr_c_next;
	logic                  ser_act_reg;
	logic                  busy;
	logic                  parity;
	logic [3:0]            abits;

	// Busy lasts until the last stop bit has left the pin.
	assign busy = state_reg != sufr_pkg::SUFR_IDLE || pop_valid
		|| ser_act_reg;
	assign push_valid = state_reg == sufr_pkg::SUFR_RUN
		&& left_reg != 6'h00;
	assign parity = ^read_data;

	// Slot in the upper pair, pending in A1, dropped read in A0.
	assign abits = multi_reg ? {slot_reg, left_reg != 6'h01, ovf_reg}
		: fixa_reg;

	// The value is sampled at push, so a later write cannot alter it.
	always_comb begin
		push_frame.long_fmt = long_reg;
		if (long_reg) begin
			push_frame.bits = {`SUFR_STOP_BITS, parity, read_data,
				abits, 1'b0};
		end else begin
			push_frame.bits = {`SUFR_PAD_SHORT, `SUFR_STOP_BITS, parity,
				read_data, 1'b0};
		end
	end

	always_comb begin
		state_next = state_reg;
		prep_next  = prep_reg;
		left_next  = left_reg;
		slot_next  = slot_reg;
		addr_next  = addr_reg;
		fixa_next  = fixa_reg;
		multi_next = multi_reg;
		long_next  = long_reg;
		ovf_next   = ovf_reg;
		wr_v_next  = wr_req && state_reg != sufr_pkg::SUFR_PREP;
		wr_c_next  = wr_cmd;
		// The command word stands until the next executed command.
		if (wr_v_next) begin
			wr_c_next = '{code: rx_sr_reg[8:1], data: rx_sr_reg[16:9]};
		end
		if (push && multi_reg && long_reg) begin
			ovf_next = 1'b0;
		end
		if (rd_req && busy) begin
			ovf_next = 1'b1;
		end
		case (state_reg)
		sufr_pkg::SUFR_IDLE: begin
			if (rd_req && !busy && !upstream_stop_bit) begin
				state_next = sufr_pkg::SUFR_PREP;
				fixa_next  = fixed_address_field;
				multi_next = multi_read_mode;
				long_next  = upstream_format_bit;
				addr_next  = rx_sr_reg[16:9];
				slot_next  = 2'h0;
				left_next  = multi_read_mode ? MULTI_FRAMES : 6'h01;
				prep_next  = multi_read_mode ? PREP_MR_CYC : PREP_SR_CYC;
			end
		end
		sufr_pkg::SUFR_PREP: begin
			if (prep_reg <= 24'h000001) begin
				state_next = sufr_pkg::SUFR_RUN;
			end else begin
				prep_next = prep_reg - 24'h000001;
			end
		end
		sufr_pkg::SUFR_RUN: begin
			if (push) begin
				left_next = left_reg - 6'h01;
				slot_next = slot_reg + 2'h1;
				addr_next = addr_reg + 8'h01;
				if (left_reg == 6'h01) begin
					state_next = sufr_pkg::SUFR_IDLE;
				end
			end
		end
		default: begin
			state_next = sufr_pkg::SUFR_IDLE;
		end
		endcase
		if (upstream_stop_bit) begin
			state_next = sufr_pkg::SUFR_IDLE;
			left_next  = 6'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg    <= sufr_pkg::SUFR_IDLE;
			prep_reg     <= 24'h000000;
			left_reg     <= 6'h00;
			slot_reg     <= 2'h0;
			addr_reg     <= 8'h00;
			fixa_reg     <= 4'h0;
			multi_reg    <= 1'b0;
			long_reg     <= 1'b0;
			ovf_reg      <= 1'b0;
			wr_cmd_valid <= 1'b0;
			wr_cmd       <= '0;
		end else begin
			state_reg    <= state_next;
			prep_reg     <= prep_next;
			left_reg     <= left_next;
			slot_reg     <= slot_next;
			addr_reg     <= addr_next;
			fixa_reg     <= fixa_next;
			multi_reg    <= multi_next;
			long_reg     <= long_next;
			ovf_reg      <= ovf_next;
			wr_cmd_valid <= wr_v_next;
			wr_cmd       <= wr_c_next;
		end
	end

	assign read_addr          = addr_reg;
	assign read_overflow_flag = ovf_reg;
	assign upstream_busy      = busy;

	// Serializer; bit time is divider plus one link clock periods.
	logic [15:0]      ser_sh_reg;
	logic [15:0]      ser_sh_next;
	logic [4:0]       ser_left_reg;
	logic [4:0]       ser_left_next;
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic             ser_act_next;
	logic             bit_next;
	logic             tick;
	logic             pin_o_next;
	logic             pin_oe_next;
	sufr_pkg::sufr_frame_t head;

	assign head      = fifo_mem_reg[fifo_rp_reg];
	assign pop_ready = ~ser_act_reg & ~upstream_stop_bit;
	// Edges are only counted while a frame runs, so the host clock
	// must keep toggling until the last stop bit is out.
	assign tick = ser_act_reg && clk_rise
		&& div_reg == upstream_divider_field;

	always_comb begin
		ser_sh_next   = ser_sh_reg;
		ser_left_next = ser_left_reg;
		div_next      = div_reg;
		ser_act_next  = ser_act_reg;
		bit_next      = upstream_out_o | ~upstream_out_oe;
		if (upstream_stop_bit) begin
			ser_act_next = 1'b0;
			bit_next     = 1'b1;
		end else if (pop) begin
			// The start bit waits for the next link clock edge, so it
			// lasts a full bit time like every other bit of the frame.
			ser_act_next  = 1'b1;
			ser_sh_next   = head.bits;
			ser_left_next = head.long_fmt ? `SUFR_LEN_LONG
				: `SUFR_LEN_SHORT;
			div_next      = upstream_divider_field;
		end else if (ser_act_reg && clk_rise) begin
			div_next = tick ? '0 : div_reg + 1'b1;
			if (tick) begin
				if (ser_left_reg == 5'h00) begin
					ser_act_next = 1'b0;
					bit_next     = 1'b1;
				end else begin
					bit_next      = ser_sh_reg[0];
					ser_sh_next   = {1'b1, ser_sh_reg[15:1]};
					ser_left_next = ser_left_reg - 5'h01;
				end
			end
		end
		// Open-drain releases for a one; push-pull drives both levels.
		pin_o_next  = upstream_drive_type_bit ? bit_next : 1'b0;
		pin_oe_next = upstream_drive_type_bit | ~bit_next;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ser_sh_reg      <= 16'hffff;
			ser_left_reg    <= 5'h00;
			div_reg         <= '0;
			ser_act_reg     <= 1'b0;
			upstream_out_o  <= 1'b0;
			upstream_out_oe <= 1'b0;
		end else begin
			ser_sh_reg      <= ser_sh_next;
			ser_left_reg    <= ser_left_next;
			div_reg         <= div_next;
			ser_act_reg     <= ser_act_next;
			upstream_out_o  <= pin_o_next;
			upstream_out_oe <= pin_oe_next;
		end
	end

endmodule : sufr_framer

// file: sufr_framer_checker.sv
// Concurrent checks on the upstream framer's ports.
`timescale 1ns/1ps
module sufr_framer_checker #(
	parameter int RSP_NS = 5000
) (
	// Clock and reset.
	input wire logic                clk,
	input wire logic                rst_n,
	// Link and upstream pins.
	input wire logic                select_n_pin,
	input wire logic                upstream_out_o,
	input wire logic                upstream_out_oe,
	// Control and status.
	input wire logic                upstream_drive_type_bit,
	input wire logic                upstream_stop_bit,
	input wire logic                wr_cmd_valid,
	input wire sufr_pkg::sufr_cmd_t wr_cmd,
	input wire logic                upstream_busy,
	input wire logic                read_overflow_flag
);
	localparam int RSP_CYC = RSP_NS / 4;
	logic pin_lvl;

	// The line has a pull-up, so a released pin reads high.
	assign pin_lvl = upstream_out_oe ? upstream_out_o : 1'b1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	od_pull_low_a: assert property ((!upstream_drive_type_bit &&
		$past(!upstream_drive_type_bit) && upstream_out_oe) |-> !upstream_out_o)
		else $error("open-drain pin driven high");
	low_in_frame_a: assert property (!pin_lvl |-> upstream_busy)
		else $error("upstream line low outside a transfer");
	stop_abort_a: assert property (upstream_stop_bit |=>
		(!upstream_busy && pin_lvl)) else $error("stop did not abort");
	wr_pulse_a: assert property (wr_cmd_valid |->
		wr_cmd.code != 8'h01 ##1 !wr_cmd_valid) else $error("bad write pulse");
	accept_select_a: assert property ($rose(upstream_busy) |-> select_n_pin)
		else $error("transfer began while selected");
	rsp_bound_a: assert property ($rose(upstream_busy) |->
		##[1:RSP_CYC] !pin_lvl) else $error("start bit too late");
	drop_flag_a: assert property ($rose(read_overflow_flag) |->
		$past(upstream_busy)) else $error("overflow set while idle");
	frame_end_a: assert property ($fell(upstream_busy) |-> pin_lvl)
		else $error("transfer ended with line low");
	bit_hold_a: assert property ($fell(pin_lvl) |=> !pin_lvl)
		else $error("bit shorter than two cycles");
endmodule : sufr_framer_checker

// file: sufr_host_model.sv
// Host controller model: link clock, select, commands, frame capture.
`timescale 1ns/1ps
module sufr_host_model (
	// Upstream pin from the device.
	input  wire logic       up_o,
	input  wire logic       up_oe,
	input  wire logic       up_busy,
	// Frame shape expected.
	input  wire logic       long_fmt,
	input  wire logic [3:0] div_field,
	// Link pins towards the device.
	output logic            link_clk_pin,
	output logic            select_n_pin,
	output logic            serial_in_pin
);
	localparam realtime HALF = 20.5;
	logic        frame_on = 1'b0;
	logic        pin_lvl;
	logic [15:0] frames [$];
	logic [15:0] word;
	int          nbits;
	realtime     bit_ns;

	// Pull-up on the upstream line.
	assign pin_lvl = up_oe ? up_o : 1'b1;

	initial begin
		link_clk_pin = 1'b0;
		select_n_pin = 1'b1;
		serial_in_pin = 1'b0;
	end

	// Clock runs in command frames and through every transfer.
	always begin
		#HALF;
		link_clk_pin = (frame_on || up_busy) ? ~link_clk_pin : 1'b0;
	end

	// Unselected data line toggles, so no stale bit looks valid.
	always @(posedge link_clk_pin) begin
		if (select_n_pin && !frame_on)
			serial_in_pin = ~serial_in_pin;
	end

	// Frame of n falling edges, LSB first; a wrong n must be ignored.
	task automatic send_raw(input logic [16:0] fw, input int n);
		frame_on = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge link_clk_pin);
			select_n_pin = 1'b0;
			serial_in_pin = fw[i];
		end
		@(posedge link_clk_pin);
		select_n_pin = 1'b1;
		repeat (2) @(posedge link_clk_pin);
		frame_on = 1'b0;
	endtask : send_raw

	// Command frame of exactly 17 falling edges.
	task automatic send_cmd(input logic [7:0] code, input logic [7:0] data);
		send_raw({data, code, 1'b1}, 17);
	endtask : send_cmd

	// Samples each bit mid-way; returns before the next start edge.
	always begin
		@(negedge pin_lvl);
		bit_ns = (div_field + 1) * 2 * HALF;
		nbits = long_fmt ? 16 : 12;
		word = 16'hffff;
		#(bit_ns / 2);
		for (int k = 0; k < nbits; k++) begin
			if (k > 0)
				#(bit_ns);
			word[k] = pin_lvl;
		end
		frames.push_back(word);
	end
endmodule : sufr_host_model

// file: sufr_framer_tb.sv
// Self-checking bench of the upstream framer.
`timescale 1ns/1ps
module sufr_framer_tb;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                drv_pp = 1'b1;
	logic [3:0]          div = 4'h0;
	logic                fmt16 = 1'b0;
	logic                multi = 1'b0;
	logic                stop = 1'b0;
	logic                lclk, sel_n, sin, up_o, up_oe, busy, ovf, wr_v;
	logic [7:0]          raddr;
	logic [7:0]          mem [256];
	sufr_pkg::sufr_cmd_t wr_c;
	sufr_pkg::sufr_cmd_t wr_last = 16'h0000;
	int                  err_total = 0;
	int                  cmp_count = 0;
	int                  wr_n = 0;
	logic                ovf_seen = 1'b0;
	logic                ok;
	logic [15:0]         w, e;
	logic [15:0]         f [4];

	sufr_framer #(.PREP_SR_NS(40), .PREP_MR_NS(1200), .RSP_NS(2000)) u_dut (
		.clk(clk), .rst_n(rst_n), .link_clk_pin(lclk), .select_n_pin(sel_n),
		.serial_in_pin(sin), .upstream_out_o(up_o), .upstream_out_oe(up_oe),
		.upstream_drive_type_bit(drv_pp), .upstream_divider_field(div),
		.upstream_format_bit(fmt16), .multi_read_mode(multi),
		.fixed_address_field(4'ha), .upstream_stop_bit(stop),
		.read_addr(raddr), .read_data(mem[raddr]), .wr_cmd_valid(wr_v),
		.wr_cmd(wr_c), .upstream_busy(busy), .read_overflow_flag(ovf));

	sufr_host_model u_host (.up_o(up_o), .up_oe(up_oe), .up_busy(busy),
		.long_fmt(fmt16), .div_field(div), .link_clk_pin(lclk),
		.select_n_pin(sel_n), .serial_in_pin(sin));

	initial begin
		forever #2 clk = ~clk;
	end

	// Records write pulses and any overflow seen.
	always @(posedge clk) begin
		if (wr_v === 1'b1) begin
			wr_n <= wr_n + 1;
			wr_last <= wr_c;
		end
		if (ovf === 1'b1)
			ovf_seen <= 1'b1;
	end

	function automatic logic [15:0] exp_frame(input logic lf,
		input logic [3:0] a, input logic [7:0] d);
		if (lf)
			return {2'b11, ^d, d, a, 1'b0};
		return {6'h3f, ^d, d, 1'b0};
	endfunction : exp_frame

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit

	// Bounded waits: start bit, end of transfer, captured frame.
	task automatic wait_start(output logic seen);
		seen = 1'b0;
		for (int i = 0; i < 600 && !seen; i++) begin
			@(posedge clk);
			seen = (u_host.pin_lvl === 1'b0);
		end
	endtask : wait_start

	task automatic idle_wait();
		for (int i = 0; i < 3000 && busy !== 1'b0; i++)
			@(posedge clk);
	endtask : idle_wait

	task automatic get_frame(output logic [15:0] fw);
		fw = 16'hxxxx;
		for (int i = 0; i < 3000 && u_host.frames.size() == 0; i++)
			@(posedge clk);
		if (u_host.frames.size() > 0)
			fw = u_host.frames.pop_front();
	endtask : get_frame

	task automatic end_of_test();
		$display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// Test sequence; in the first two single reads the data changes mid-transfer.
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i * 37 + 3);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			@(posedge clk);
			drv_pp <= (t == 0);
			div <= 4'(t * 2);
			u_host.send_cmd(8'h01, 8'(5 + t));
			wait_start(ok);
			chk_bit(ok, 1'b1);
			e = exp_frame(1'b0, 4'h0, mem[5 + t]);
			mem[5 + t] = ~mem[5 + t];
			get_frame(w);
			chk_word(w, e);
			idle_wait();
		end
		@(posedge clk);
		fmt16 <= 1'b1;
		drv_pp <= 1'b1;
		div <= 4'h1;
		for (int t = 0; t < 2; t++) begin
			u_host.send_cmd(8'h01, 8'(16 << t));
			get_frame(w);
			chk_word(w, exp_frame(1'b1, 4'ha, mem[16 << t]));
			idle_wait();
		end
		@(posedge clk);
		multi <= 1'b1;
		u_host.send_cmd(8'h01, 8'h40);
		u_host.send_cmd(8'h22, 8'h11);
		wait_start(ok);
		u_host.send_cmd(8'h01, 8'h80);
		u_host.send_cmd(8'h33, 8'h44);
		for (int k = 0; k < 4; k++) begin
			get_frame(f[k]);
			e = exp_frame(1'b1, {2'(k), k < 3, 1'b0}, mem[64 + k]);
			chk_word(f[k] & 16'hfffd, e);
		end
		chk_bit(f[0][1], 1'b0);
		chk_bit(f[2][1] | f[3][1], 1'b1);
		chk_bit(ovf_seen, 1'b1);
		chk_word(16'(wr_n), 16'h0001);
		chk_word(wr_last, 16'h3344);
		idle_wait();
		u_host.send_cmd(8'h55, 8'h66);
		repeat (4) @(posedge clk);
		chk_word(wr_last, 16'h5566);
		u_host.send_raw({8'h77, 8'h88, 1'b1}, 16);
		repeat (4) @(posedge clk);
		chk_word(16'(wr_n), 16'h0002);
		u_host.send_cmd(8'h01, 8'h07);
		wait_start(ok);
		repeat (40) @(posedge clk);
		stop <= 1'b1;
		@(posedge clk);
		stop <= 1'b0;
		repeat (2) @(posedge clk);
		chk_bit(busy, 1'b0);
		u_host.frames.delete();
		repeat (2500) @(posedge clk);
		chk_word(16'(u_host.frames.size()), 16'h0001);
		end_of_test();
	end

	// Cuts a hang short well after the sequence should finish.
	initial begin
		#100000;
		err_total++;
		end_of_test();
	end
endmodule : sufr_framer_tb

bind sufr_framer sufr_framer_checker #(.RSP_NS(RSP_NS)) u_chk (
	.clk(clk), .rst_n(rst_n), .select_n_pin(select_n_pin),
	.upstream_out_o(upstream_out_o), .upstream_out_oe(upstream_out_oe),
	.upstream_drive_type_bit(upstream_drive_type_bit),
	.upstream_stop_bit(upstream_stop_bit), .wr_cmd_valid(wr_cmd_valid),
	.wr_cmd(wr_cmd), .upstream_busy(upstream_busy),
	.read_overflow_flag(read_overflow_flag));
